// [can_ts_pkg.sv]
package can_ts_pkg;

  // Register byte offsets
  localparam logic [7:0] TBC_LOW_OFS  = 8'h00;
  localparam logic [7:0] TBC_HIGH_OFS = 8'h04;
  localparam logic [7:0] TSCTL_OFS    = 8'h08;
  localparam logic [7:0] TSPRE_OFS    = 8'h0c;
  localparam logic [7:0] VECH_OFS     = 8'h10;
  localparam logic [7:0] VECL_OFS     = 8'h14;
  localparam logic [7:0] IEN_OFS      = 8'h18;
  localparam logic [7:0] IFLAG_OFS    = 8'h1c;

  // Timestamp control fields
  localparam int TBEN_BIT   = 0;
  localparam int EOFSEL_BIT = 1;
  localparam int FDSEL_BIT  = 2;
  localparam int PRE_W      = 10;

  // Implemented-bit masks
  localparam logic [15:0] TSCTL_MASK = 16'h0007;
  localparam logic [15:0] TSPRE_MASK = 16'h03ff;
  localparam logic [15:0] IEN_MASK   = 16'hfc1f;
  localparam logic [15:0] IFLAG_CLR  = 16'hf00c;

  // Reset values
  localparam logic [15:0] TSCTL_RST = 16'h0000;
  localparam logic [15:0] TSPRE_RST = 16'h0000;
  localparam logic [15:0] IEN_RST   = 16'h0000;
  localparam logic [31:0] TBC_RST   = 32'h0000_0000;

  // Enable and flag bit positions
  localparam int IVM_BIT = 15;
  localparam int WAK_BIT = 14;
  localparam int BER_BIT = 13;
  localparam int SER_BIT = 12;
  localparam int ROV_BIT = 11;
  localparam int TAT_BIT = 10;
  localparam int TEF_BIT = 4;
  localparam int MOD_BIT = 3;
  localparam int TBO_BIT = 2;
  localparam int RXO_BIT = 1;
  localparam int TXO_BIT = 0;

  // Vector codes
  localparam logic [6:0] CODE_NONE  = 7'h40;
  localparam logic [6:0] CODE_BERR  = 7'h41;
  localparam logic [6:0] CODE_WAKE  = 7'h42;
  localparam logic [6:0] CODE_RXOV  = 7'h43;
  localparam logic [6:0] CODE_ADDR  = 7'h44;
  localparam logic [6:0] CODE_MAB   = 7'h45;
  localparam logic [6:0] CODE_TBOV  = 7'h46;
  localparam logic [6:0] CODE_MODE  = 7'h47;
  localparam logic [6:0] CODE_IVM   = 7'h48;
  localparam logic [6:0] CODE_TEF   = 7'h49;
  localparam logic [6:0] CODE_TXAT  = 7'h4a;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Frame position pulses from the bit engine
  typedef struct packed {
    logic sofSample;
    logic fdfSample;
    logic fdfValue;
    logic afterFdfSample;
    logic rxEofValid;
    logic txEofValid;
  } frame_event_type;

  // Controller-wide event pulses and status levels
  typedef struct packed {
    logic       invalidMsg;
    logic       wakeup;
    logic       busError;
    logic       mabFault;
    logic       addrFault;
    logic       modeChange;
    logic       rxOverflowAny;
    logic       txAttemptAny;
    logic       tefAny;
    logic [7:0] receive_fifo_flag;
    logic [7:0] transmit_fifo_flag;
  } ctrl_status_type;

  typedef enum logic [2:0] {
    STAMP_IDLE = 3'b001,
    STAMP_FDF  = 3'b010,
    STAMP_NEXT = 3'b100
  } stamp_state_type;

endpackage : can_ts_pkg

// [can_timestamp_vector.sv]
// What this block does
// - Enabled counter advances once per prescaler period
// - Enable cleared stops counter, zeroes count
// - Counter writes, when enabled, load that half and clear prescaler count
// - Prescaler N advances every N+1 clocks
// - FD stamp after FDF bit or SOF
// - End-of-frame stamp on valid rx/tx frame
// - Otherwise classical at SOF, FD per select
// - Receive code: highest FIFO 1-7, else 0x40
// - Transmit code: highest FIFO 0-7, else 0x40
// - Read-only matched filter number field
// - General code: attempt, event, invalid, mode, overflow
// - General code: MESSAGE_ASSEMBLY_BUFFER, address, rxov, wake, error
// - General code FIFO n, else 0x40
// - Upper-byte enables, read/write, reset zero
// - Lower-byte enables, read/write, reset zero
// - Unimplemented bits read zero, ignore writes
// - Counter 32 bits, upper half companion
// - Sticky flags set by hardware, cleared by software; receive overflow, attempt, event and FIFO flags follow status levels
`timescale 1ns/1ps
`default_nettype none

module can_timestamp_vector
  import can_ts_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            srst,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output var  logic            s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output var  logic            s_axi_wready,
  output var  logic [1:0]      s_axi_bresp,
  output var  logic            s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output var  logic            s_axi_arready,
  output var  logic [31:0]     s_axi_rdata,
  output var  logic [1:0]      s_axi_rresp,
  output var  logic            s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire frame_event_type frameEv,
  input  wire ctrl_status_type ctrlSt,
  input  wire logic [4:0]      filterHit,
  input  wire logic            filterHitValid,
  output var  logic [31:0]     stampValue,
  output var  logic            stampValid,
  output var  logic            canIrq
);

  // Highest set bit index of an 8-bit vector, with presence
  function automatic logic [3:0] top_index(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : top_index

  // Merge write data into a 16-bit register under strobes and mask
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
    logic [15:0] n;
    n = old;
    if (s[0]) begin
      n[7:0] = d[7:0];
    end
    if (s[1]) begin
      n[15:8] = d[15:8];
    end
    return n & m;
  endfunction : merge16

  // Storage
  logic [31:0]        time_base_counter_r;
  logic [PRE_W-1:0]   preCnt_r;
  logic [15:0]        tsctl_r;
  logic [15:0]        tspre_r;
  logic [15:0]        ien_r;
  logic [15:0]        iflag_r;
  logic               mabCause_r;
  logic               addrCause_r;
  logic [4:0]         filter_match_number_r;
  logic [6:0]         receive_vector_code_r;
  logic [6:0]         transmit_vector_code_r;
  logic [6:0]         genCode_r;
  logic [31:0]        sofStamp_r;
  stamp_state_type    stampState_r;
  stamp_state_type    stampState_nxt;

  // AXI slave state
  logic        awHeld_r;
  logic        wHeld_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;

  // Control field decode
  wire                   time_base_enable           = tsctl_r[TBEN_BIT];
  wire                   end_of_frame_stamp_select  = tsctl_r[EOFSEL_BIT];
  wire                   fd_stamp_point_select      = tsctl_r[FDSEL_BIT];
  wire logic [PRE_W-1:0] time_base_prescaler        = tspre_r[PRE_W-1:0];

  // Write channel handshake
  wire awFire   = s_axi_awvalid & s_axi_awready;
  wire wFire    = s_axi_wvalid & s_axi_wready;
  wire addrHave = awHeld_r | awFire;
  wire dataHave = wHeld_r | wFire;
  wire doWrite  = addrHave & dataHave & ~s_axi_bvalid;
  wire logic [7:0]  wAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
  wire logic [31:0] wData = wHeld_r ? wData_r : s_axi_wdata;
  wire logic [3:0]  wStrb = wHeld_r ? wStrb_r : s_axi_wstrb;
  wire wrTbcLow  = doWrite & (wAddr == TBC_LOW_OFS);
  wire wrTbcHigh = doWrite & (wAddr == TBC_HIGH_OFS);
  wire wrTsctl   = doWrite & (wAddr == TSCTL_OFS);
  wire wrTspre   = doWrite & (wAddr == TSPRE_OFS);
  wire wrIen     = doWrite & (wAddr == IEN_OFS);
  wire wrIflag   = doWrite & (wAddr == IFLAG_OFS);
  wire wrMapped  = wrTbcLow | wrTbcHigh | wrTsctl | wrTspre | wrIen | wrIflag |
                   (wAddr == VECH_OFS) | (wAddr == VECL_OFS);

  // Time base tick and overflow
  wire tbWrite  = wrTbcLow | wrTbcHigh;
  wire tbTick   = time_base_enable & ~tbWrite & (preCnt_r == time_base_prescaler);
  wire tbWrap   = tbTick & (time_base_counter_r == 32'hffff_ffff);

  // Flag set and clear terms; software writes 0 to clear a clearable flag
  wire logic [15:0] flagSet;
  wire logic [15:0] flagClr;
  assign flagSet[IVM_BIT] = ctrlSt.invalidMsg;
  assign flagSet[WAK_BIT] = ctrlSt.wakeup;
  assign flagSet[BER_BIT] = ctrlSt.busError;
  assign flagSet[SER_BIT] = ctrlSt.mabFault | ctrlSt.addrFault;
  assign flagSet[MOD_BIT] = ctrlSt.modeChange;
  assign flagSet[TBO_BIT] = tbWrap;
  assign {flagSet[11:4], flagSet[1:0]} = '0;
  assign flagClr = wrIflag ? (~merge16(16'hffff, wData, wStrb, 16'hffff) & IFLAG_CLR) : 16'h0;

  // Live flag view: sticky bits plus level status from elsewhere
  wire logic [15:0] flagView;
  assign flagView[IVM_BIT:SER_BIT] = iflag_r[IVM_BIT:SER_BIT];
  assign flagView[ROV_BIT] = ctrlSt.rxOverflowAny;
  assign flagView[TAT_BIT] = ctrlSt.txAttemptAny;
  assign flagView[9:5]     = 5'h00;
  assign flagView[TEF_BIT] = ctrlSt.tefAny;
  assign flagView[MOD_BIT] = iflag_r[MOD_BIT];
  assign flagView[TBO_BIT] = iflag_r[TBO_BIT];
  assign flagView[RXO_BIT] = |ctrlSt.receive_fifo_flag[7:1];
  assign flagView[TXO_BIT] = |ctrlSt.transmit_fifo_flag;
  wire logic [15:0] pend = flagView & ien_r;

  // FIFO code selection, highest index first
  wire logic [7:0] rxValid = {ctrlSt.receive_fifo_flag[7:1], 1'b0};
  wire logic [3:0] rxTop   = top_index(rxValid);
  wire logic [3:0] txTop   = top_index(ctrlSt.transmit_fifo_flag);
  wire logic [7:0] anyFifo = (ien_r[RXO_BIT] ? rxValid : 8'h00) |
                             (ien_r[TXO_BIT] ? ctrlSt.transmit_fifo_flag : 8'h00);
  wire logic [3:0] anyTop  = top_index(anyFifo);
  wire logic [6:0] rxCodeNxt = rxTop[3] ? {4'h0, rxTop[2:0]} : CODE_NONE;
  wire logic [6:0] txCodeNxt = txTop[3] ? {4'h0, txTop[2:0]} : CODE_NONE;

  // General code priority chain, higher code first
  wire logic [6:0] genCodeNxt =
    pend[TAT_BIT]                  ? CODE_TXAT :
    pend[TEF_BIT]                  ? CODE_TEF  :
    pend[IVM_BIT]                  ? CODE_IVM  :
    pend[MOD_BIT]                  ? CODE_MODE :
    pend[TBO_BIT]                  ? CODE_TBOV :
    (pend[SER_BIT] & mabCause_r)   ? CODE_MAB  :
    (pend[SER_BIT] & addrCause_r)  ? CODE_ADDR :
    pend[ROV_BIT]                  ? CODE_RXOV :
    pend[WAK_BIT]                  ? CODE_WAKE :
    pend[BER_BIT]                  ? CODE_BERR :
    anyTop[3]                      ? {4'h0, anyTop[2:0]} :
                                     CODE_NONE;

  // Read decode, unimplemented bits zero
  wire logic [15:0] rdMux =
    (s_axi_araddr == TBC_LOW_OFS)  ? time_base_counter_r[15:0] :
    (s_axi_araddr == TBC_HIGH_OFS) ? time_base_counter_r[31:16] :
    (s_axi_araddr == TSCTL_OFS)    ? tsctl_r :
    (s_axi_araddr == TSPRE_OFS)    ? tspre_r :
    (s_axi_araddr == VECH_OFS)     ? {1'b0, receive_vector_code_r, 1'b0, transmit_vector_code_r} :
    (s_axi_araddr == VECL_OFS)     ? {3'b000, filter_match_number_r, 1'b0, genCode_r} :
    (s_axi_araddr == IEN_OFS)      ? ien_r :
    (s_axi_araddr == IFLAG_OFS)    ? flagView : 16'h0000;
  wire rdMapped = (s_axi_araddr == TBC_LOW_OFS) | (s_axi_araddr == TBC_HIGH_OFS) |
                  (s_axi_araddr == TSCTL_OFS) | (s_axi_araddr == TSPRE_OFS) |
                  (s_axi_araddr == VECH_OFS) | (s_axi_araddr == VECL_OFS) |
                  (s_axi_araddr == IEN_OFS) | (s_axi_araddr == IFLAG_OFS);

  // Write channel: take address and data in either order
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      awAddr_r      <= 8'h00;
      wData_r       <= 32'h0;
      wStrb_r       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (awFire) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (wFire) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_awready <= ~addrHave & ~doWrite & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~dataHave & ~doWrite & ~s_axi_wready & ~s_axi_bvalid;
    end
  end

  // Read channel: one read at a time, data registered
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rdMux};
        s_axi_rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else begin
        s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      end
    end
  end

  // Control registers, writable bits only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tsctl_r <= TSCTL_RST;
      tspre_r <= TSPRE_RST;
      ien_r   <= IEN_RST;
    end else begin
      if (wrTsctl) begin
        tsctl_r <= merge16(tsctl_r, wData, wStrb, TSCTL_MASK);
      end
      if (wrTspre) begin
        tspre_r <= merge16(tspre_r, wData, wStrb, TSPRE_MASK);
      end
      if (wrIen) begin
        ien_r <= merge16(ien_r, wData, wStrb, IEN_MASK);
      end
    end
  end

  // Prescaler and 32-bit time base
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      time_base_counter_r <= TBC_RST;
      preCnt_r            <= '0;
    end else if (!time_base_enable) begin
      time_base_counter_r <= TBC_RST;
      preCnt_r            <= '0;
    end else if (tbWrite) begin
      preCnt_r <= '0;
      if (wrTbcLow) begin
        time_base_counter_r[15:0] <= merge16(time_base_counter_r[15:0], wData, wStrb, 16'hffff);
      end
      if (wrTbcHigh) begin
        time_base_counter_r[31:16] <= merge16(time_base_counter_r[31:16], wData, wStrb, 16'hffff);
      end
    end else if (tbTick) begin
      preCnt_r            <= '0;
      time_base_counter_r <= time_base_counter_r + 32'h1;
    end else begin
      preCnt_r <= preCnt_r + 10'h001;
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      iflag_r     <= 16'h0000;
      mabCause_r  <= 1'b0;
      addrCause_r <= 1'b0;
    end else begin
      iflag_r <= ((iflag_r & ~flagClr) | flagSet) & IFLAG_CLR;
      if (ctrlSt.mabFault) begin
        mabCause_r <= 1'b1;
      end else if (flagClr[SER_BIT]) begin
        mabCause_r <= 1'b0;
      end
      if (ctrlSt.addrFault) begin
        addrCause_r <= 1'b1;
      end else if (flagClr[SER_BIT]) begin
        addrCause_r <= 1'b0;
      end
    end
  end

  // Vector codes, filter hit and request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      receive_vector_code_r              <= CODE_NONE;
      transmit_vector_code_r              <= CODE_NONE;
      genCode_r             <= CODE_NONE;
      filter_match_number_r <= 5'h00;
      canIrq                <= 1'b0;
    end else begin
      receive_vector_code_r  <= rxCodeNxt;
      transmit_vector_code_r  <= txCodeNxt;
      genCode_r <= genCodeNxt;
      canIrq    <= |pend;
      if (filterHitValid) begin
        filter_match_number_r <= filterHit;
      end
    end
  end

  // Frame stamp sequencer next state
  always_comb begin
    stampState_nxt = stampState_r;
    case (stampState_r)
      STAMP_IDLE: begin
        if (frameEv.sofSample & ~end_of_frame_stamp_select) begin
          stampState_nxt = STAMP_FDF;
        end
      end
      STAMP_FDF: begin
        if (frameEv.fdfSample) begin
          stampState_nxt = (frameEv.fdfValue & fd_stamp_point_select) ? STAMP_NEXT : STAMP_IDLE;
        end
      end
      STAMP_NEXT: begin
        if (frameEv.afterFdfSample) begin
          stampState_nxt = STAMP_IDLE;
        end
      end
      default: stampState_nxt = STAMP_IDLE;
    endcase
  end

  // Frame stamp capture
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stampState_r <= STAMP_IDLE;
      sofStamp_r   <= 32'h0;
      stampValue   <= 32'h0;
      stampValid   <= 1'b0;
    end else begin
      stampState_r <= stampState_nxt;
      stampValid   <= 1'b0;
      if (frameEv.sofSample) begin
        sofStamp_r <= time_base_counter_r;
      end
      if (end_of_frame_stamp_select & (frameEv.rxEofValid | frameEv.txEofValid)) begin
        stampValue <= time_base_counter_r;
        stampValid <= 1'b1;
      end else if (stampState_r == STAMP_FDF && frameEv.fdfSample &&
                   !(frameEv.fdfValue && fd_stamp_point_select)) begin
        stampValue <= sofStamp_r;
        stampValid <= 1'b1;
      end else if (stampState_r == STAMP_NEXT && frameEv.afterFdfSample) begin
        stampValue <= time_base_counter_r;
        stampValid <= 1'b1;
      end
    end
  end

endmodule : can_timestamp_vector

`default_nettype wire

// [can_ts_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module can_ts_checker
  import can_ts_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            srst,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic            s_axi_bvalid,
  input wire logic [7:0]      s_axi_araddr,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic [1:0]      s_axi_rresp,
  input wire logic            s_axi_rvalid,
  input wire frame_event_type frameEv,
  input wire logic            stampValid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Bus transfer steps
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // A read shows only the implemented bits of its register
  property rdMask(logic [7:0] a, logic [31:0] m);
    rdTaken ##0 (s_axi_araddr == a) |=> (s_axi_rdata & ~m) == 32'h0;
  endproperty
  read_answer_a: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  write_answer_a: assert property (wrTaken |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  unmapped_read_a: assert property (rdTaken ##0 (s_axi_araddr > 8'h1c) |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  ctl_bits_a: assert property (rdMask(TSCTL_OFS, {16'h0, TSCTL_MASK}))
    else $error("timestamp control spare bits set");
  pre_bits_a: assert property (rdMask(TSPRE_OFS, {16'h0, TSPRE_MASK}))
    else $error("prescaler spare bits set");
  enable_bits_a: assert property (rdMask(IEN_OFS, {16'h0, IEN_MASK}))
    else $error("enable spare bits set");
  rxtx_code_a: assert property (rdMask(VECH_OFS, 32'h7f7f))
    else $error("rx tx code spare bits set");
  filter_code_a: assert property (rdMask(VECL_OFS, 32'h1f7f))
    else $error("filter code spare bits set");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  stamp_cause_a: assert property (stampValid |-> $past(frameEv.fdfSample ||
    frameEv.afterFdfSample || frameEv.rxEofValid || frameEv.txEofValid) ##1 !stampValid)
    else $error("stamp without frame point");
endmodule : can_ts_checker

bind can_timestamp_vector can_ts_checker chk (.ref_clk(ref_clk), .srst(srst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .frameEv(frameEv), .stampValid(stampValid));
`default_nettype wire

// [can_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model
  import can_ts_pkg::*;
(
  input  wire logic            ref_clk,
  output var  frame_event_type frameEv,
  output var  ctrl_status_type ctrlSt
);
  // Quiet controller at start
  initial begin
    frameEv = '0;
    ctrlSt  = '0;
  end
  // Events pulse one cycle, status levels persist
  task automatic st(input logic [24:0] m);
    @(posedge ref_clk);
    ctrlSt <= m;
    @(posedge ref_clk);
    ctrlSt <= m & 25'h007ffff;
  endtask : st
  // Frame points: start, format bit, bit after it, valid end of frame
  task automatic frame(input logic fd, input logic rx);
    for (int i = 0; i < 19; i++) begin
      @(posedge ref_clk);
      frameEv <= (i == 0) ? 6'h20 : (i == 4) ? {2'b01, fd, 3'h0} :
                 (i == 6) ? 6'h04 : (i == 17) ? {4'h0, rx, !rx} : 6'h00;
    end
  endtask : frame
endmodule : can_ctrl_model
`default_nettype wire

// [can_timestamp_and_interrupt_vector_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module can_timestamp_and_interrupt_vector_tb;
  import can_ts_pkg::*;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0]  filterHit = 5'h0;
  logic        filterHitValid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, stampValid, canIrq, ei, sfd, srx;
  logic [1:0]  bresp, rresp, respV;
  logic [31:0] rdata, stampValue, cyc = 32'h0, tk, t0, tw, rdv, stampD, dRef, n0, sx;
  logic [24:0] m;
  logic [6:0]  eg, er, et;
  logic [2:0]  sc;
  int          errors = 0, nChecks = 0, nStamps = 0;
  frame_event_type frameEv;
  ctrl_status_type ctrlSt;
  logic [9:0]  preTab [3] = '{10'd0, 10'd2, 10'd1023};
  logic [31:0] dTab [3] = '{32'd20, 32'd30, 32'd2048};
  logic [46:0] codeTab [14] = '{{25'h1000000, 7'h48, 7'h40, 7'h40, 1'b1},
    {25'h0800000, 7'h42, 7'h40, 7'h40, 1'b1}, {25'h0400000, 7'h41, 7'h40, 7'h40, 1'b1},
    {25'h0200000, 7'h45, 7'h40, 7'h40, 1'b1}, {25'h0100000, 7'h44, 7'h40, 7'h40, 1'b1},
    {25'h0080000, 7'h47, 7'h40, 7'h40, 1'b1}, {25'h0040000, 7'h43, 7'h40, 7'h40, 1'b1},
    {25'h0020000, 7'h4a, 7'h40, 7'h40, 1'b1}, {25'h0010000, 7'h49, 7'h40, 7'h40, 1'b1},
    {25'h0002800, 7'h05, 7'h05, 7'h40, 1'b1}, {25'h0000081, 7'h07, 7'h40, 7'h07, 1'b1},
    {25'h0000001, 7'h00, 7'h40, 7'h00, 1'b1}, {25'h0000100, 7'h40, 7'h40, 7'h40, 1'b0},
    {25'h1c40000, 7'h48, 7'h40, 7'h40, 1'b1}};
  logic [36:0] stampTab [5] = '{{3'b011, 1'b1, 1'b0, 32'h0},
    {3'b001, 1'b0, 1'b1, 32'hfffffffc}, {3'b001, 1'b1, 1'b1, 32'hfffffffc},
    {3'b101, 1'b1, 1'b1, 32'h0}, {3'b101, 1'b0, 1'b1, 32'hfffffffc}};

  can_timestamp_vector dut (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frameEv(frameEv),
    .ctrlSt(ctrlSt), .filterHit(filterHit), .filterHitValid(filterHitValid),
    .stampValue(stampValue), .stampValid(stampValid), .canIrq(canIrq));
  can_ctrl_model partner (.ref_clk(ref_clk), .frameEv(frameEv), .ctrlSt(ctrlSt));

  // Clock, cycle count and stamp monitor
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 32'h1;
    if (stampValid) begin
      stampD  <= stampValue - cyc;
      nStamps <= nStamps + 1;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= {16'h0, d};
    wstrb   <= 4'h3;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    tw = cyc; // Edge after the one at which the write landed
    respV = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready && arvalid) tk = cyc;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rdv = rdata;
    respV = rresp;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    check($sformatf("reg %h", a), rdv, {16'h0, e});
  endtask : rc

  task automatic close_out;
    $display("checks %0d mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Watchdog
  initial begin
    #2_000_000;
    errors++;
    close_out();
  end

  // Test sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    rc(TSCTL_OFS, TSCTL_RST);
    rc(IEN_OFS, IEN_RST);
    rc(VECH_OFS, 16'h4040);
    rc(VECL_OFS, 16'h0040);
    wr(8'h20, 16'h1234);
    check("write resp", respV, RESP_SLVERR);
    rc(8'h24, 16'h0000);
    check("read resp", respV, RESP_SLVERR);
    $display("test reset and unmapped done");
    wr(TSCTL_OFS, 16'hfff8);
    rc(TSCTL_OFS, 16'h0000);
    wr(TSPRE_OFS, 16'hffff);
    rc(TSPRE_OFS, 16'h03ff);
    wr(IEN_OFS, 16'hffff);
    rc(IEN_OFS, IEN_MASK);
    wr(IEN_OFS, 16'h0000);
    filterHit      <= 5'h0f;
    filterHitValid <= 1'b1;
    @(posedge ref_clk);
    filterHitValid <= 1'b0;
    rc(VECL_OFS, 16'h0f40);
    $display("test field masks done");
    foreach (preTab[i]) begin
      wr(TSCTL_OFS, 16'h0000);
      rc(TBC_LOW_OFS, 16'h0000);
      wr(TSPRE_OFS, {6'h0, preTab[i]});
      wr(TSCTL_OFS, 16'h0001);
      rd(TBC_LOW_OFS);
      t0 = tk;
      check("start count", rdv, (t0 - tw) / ({22'h0, preTab[i]} + 32'd1));
      while (cyc != t0 + dTab[i] - 32'd2) @(posedge ref_clk);
      rd(TBC_LOW_OFS);
      check("count rate", rdv, (tk - tw) / ({22'h0, preTab[i]} + 32'd1));
    end
    wr(TSCTL_OFS, 16'h0000);
    wr(TSCTL_OFS, 16'h0001);
    repeat (1000) @(posedge ref_clk);
    wr(TBC_LOW_OFS, 16'h0005);
    repeat (600) @(posedge ref_clk);
    rc(TBC_LOW_OFS, 16'h0005);
    $display("test time base rate done");
    wr(TSPRE_OFS, 16'h0000);
    wr(TBC_HIGH_OFS, 16'hffff);
    rc(TBC_HIGH_OFS, 16'hffff);
    wr(TBC_LOW_OFS, 16'hfff0);
    repeat (40) @(posedge ref_clk);
    wr(TSCTL_OFS, 16'h0000);
    rc(IFLAG_OFS, 16'h0004);
    wr(IEN_OFS, 16'h0004);
    rc(VECL_OFS, 16'h0f46);
    check("irq", canIrq, 32'h1);
    wr(IFLAG_OFS, 16'h0000);
    rc(IFLAG_OFS, 16'h0000);
    check("irq", canIrq, 32'h0);
    partner.st(25'h0800000);
    rc(VECL_OFS, 16'h0f40);
    check("irq", canIrq, 32'h0);
    wr(IEN_OFS, IEN_MASK);
    rc(VECL_OFS, 16'h0f42);
    wr(IFLAG_OFS, 16'h0000);
    $display("test overflow and masking done");
    foreach (codeTab[i]) begin
      {m, eg, er, et, ei} = codeTab[i];
      partner.st(m);
      rc(VECL_OFS, {8'h0f, 1'b0, eg});
      rc(VECH_OFS, {1'b0, er, 1'b0, et});
      check("irq", canIrq, {31'h0, ei});
      partner.st(25'h0);
      wr(IFLAG_OFS, 16'h0000);
    end
    $display("test vector codes done");
    wr(TSCTL_OFS, 16'h0003);
    partner.frame(1'b0, 1'b1);
    repeat (3) @(posedge ref_clk);
    dRef = stampD;
    foreach (stampTab[i]) begin
      {sc, sfd, srx, sx} = stampTab[i];
      wr(TSCTL_OFS, {13'h0, sc});
      n0 = nStamps;
      partner.frame(sfd, srx);
      repeat (3) @(posedge ref_clk);
      check("stamp count", nStamps - n0, 32'h1);
      check("stamp time", stampD - dRef, sx);
    end
    $display("test stamp points done");
    close_out();
  end
endmodule : can_timestamp_and_interrupt_vector_tb
`default_nettype wire
